// file: hw/wake_on_network_filter.sv
// receive-side wake-on-network filter: apb registers, event flags, wake output
// assumes frame verdicts from the receive path, synchronous to pclk
//
// Functional notes
// [RULE1] writing wake_output_clear drops a level wake; self-clears; no effect when pulsing
// [RULE2] pulse width is 8, 16, 32 or 64 reference cycles by wake_pulse_length
// [RULE3] wake_output_style one holds wake until cleared, zero gives stretched pulse
// [RULE4] wake, crc check and timestamp indication work only under enhanced_receive_enable
// [RULE5] with password_check_enable a magic packet needs the right password
// [RULE6] unicast_wake_enable makes valid unicast packets wake; resets to zero
// [RULE7] broadcast_wake_enable makes valid broadcast packets wake; resets to one
// [RULE8] pattern wake enable makes pattern-matching packets wake; resets to zero
// [RULE9] magic wake enable makes valid magic packets wake; resets to zero
// [RULE10] delimiter_error_flag latches on a missing delimiter, cleared by status read
// [RULE11] bad crc flag latches on a crc failure, cleared by status read
// [RULE12] password_hack_flag latches on a wrong password, cleared by status read
// [RULE13] unicast_seen_flag latches on a valid unicast packet, cleared by status read
// [RULE14] broadcast_seen_flag latches on a valid broadcast packet, cleared by status read
// [RULE15] pattern_seen_flag latches on a valid pattern packet, cleared by status read
// [RULE16] magic_seen_flag latches on a valid magic packet, cleared by status read
// [RULE17] 48-bit password in three 16-bit registers, low bits first
// [RULE18] reserved bits read zero and ignore writes
// [RULE19] wake only for enabled sources; flags latch regardless of enables
`timescale 1ns/100ps
`default_nettype none
`include "wake_filter_defs.svh"

module wake_on_network_filter (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // receive path
  input wire wake_filter_pkg::rx_summary_t rx_summary,
  input wire logic rx_frame_start,
  // outputs
  output logic rx_timestamp_event,
  output logic wake_on_network,
  output logic irq
);
  import wake_filter_pkg::*;

  // ************************************
  // apb decode
  // ************************************
  logic setup_phase;
  logic access_done;
  logic wr_done;
  logic rd_done;
  logic hit_cfg;
  logic hit_sts;
  logic hit_pw0;
  logic hit_pw1;
  logic hit_pw2;
  logic hit_mask;
  logic hit_any;
  logic [31:0] rd_mux;
  logic [31:0] prdata_q;
  logic pslverr_q;

  assign setup_phase = psel & ~penable;
  assign access_done = psel & penable;
  assign wr_done = access_done & pwrite & ~pslverr_q;
  assign rd_done = access_done & ~pwrite & ~pslverr_q;
  assign hit_cfg = paddr == `BYTE_ADDR(`CFG_INDEX);
  assign hit_sts = paddr == `BYTE_ADDR(`STS_INDEX);
  assign hit_pw0 = paddr == `BYTE_ADDR(`PW0_INDEX);
  assign hit_pw1 = paddr == `BYTE_ADDR(`PW1_INDEX);
  assign hit_pw2 = paddr == `BYTE_ADDR(`PW2_INDEX);
  assign hit_mask = paddr == `BYTE_ADDR(`MASK_INDEX);
  assign hit_any = hit_cfg | hit_sts | hit_pw0 | hit_pw1 | hit_pw2 | hit_mask;

  // no wait state: read data is sampled in setup so that prdata comes from a flop
  assign pready = access_done;
  assign prdata = prdata_q;
  assign pslverr = pslverr_q & access_done;

  // ************************************
  // registers
  // ************************************
  logic [15:0] cfg_q;
  logic [7:0] sts_q;
  logic [7:0] sts_d;
  logic [7:0] mask_q;
  logic [47:0] pw_q;
  logic [7:0] events;
  logic enhanced;
  logic style_level;
  logic [1:0] stretch;

  assign enhanced = cfg_q[`CFG_ENHANCED];
  assign style_level = cfg_q[`CFG_OUT_STYLE];
  assign stretch = cfg_q[`CFG_STRETCH_HI:`CFG_STRETCH_LO];

  always_comb begin
    rd_mux = 32'h0000_0000;
    if (hit_cfg) begin
      rd_mux = {16'h0000, cfg_q}; // see [RULE18]
    end else if (hit_sts) begin
      rd_mux = {24'h00_0000, sts_q};
    end else if (hit_pw0) begin
      rd_mux = {16'h0000, pw_q[15:0]};
    end else if (hit_pw1) begin
      rd_mux = {16'h0000, pw_q[31:16]};
    end else if (hit_pw2) begin
      rd_mux = {16'h0000, pw_q[47:32]};
    end else if (hit_mask) begin
      rd_mux = {24'h00_0000, mask_q};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end else if (setup_phase) begin
      prdata_q <= pwrite ? 32'h0000_0000 : rd_mux;
      pslverr_q <= ~hit_any;
    end
  end

  // config: reserved bits never store, the clear bit lasts one cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_q <= `CFG_RESET; // see [RULE6] [RULE7] [RULE8] [RULE9]
    end else if (wr_done && hit_cfg) begin
      cfg_q <= pwdata[15:0] & `CFG_WRITE_MASK; // see [RULE18]
    end else begin
      cfg_q[`CFG_OUT_CLEAR] <= 1'b0; // see [RULE1]
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pw_q <= 48'h0000_0000_0000;
    end else if (wr_done) begin
      if (hit_pw0) begin
        pw_q[15:0] <= pwdata[15:0]; // see [RULE17]
      end
      if (hit_pw1) begin
        pw_q[31:16] <= pwdata[15:0]; // see [RULE17]
      end
      if (hit_pw2) begin
        pw_q[47:32] <= pwdata[15:0]; // see [RULE17]
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_q <= 8'h00;
    end else if (wr_done && hit_mask) begin
      mask_q <= pwdata[7:0] & `STS_USED_MASK;
    end
  end

  // ************************************
  // frame classification
  // ************************************
  logic frame_good;
  logic pw_match;
  logic magic_ok;
  logic hack;
  logic wake_hit;

  assign frame_good = rx_summary.sfd_ok & rx_summary.crc_ok;
  // a missing password counts as wrong when checking is on
  assign pw_match = rx_summary.password_seen & (rx_summary.password == pw_q);
  assign magic_ok = rx_summary.magic & (~cfg_q[`CFG_PW_EN] | pw_match); // see [RULE5]
  assign hack = rx_summary.magic & cfg_q[`CFG_PW_EN] & ~pw_match; // see [RULE12]

  always_comb begin
    events = 8'h00;
    if (rx_summary.done) begin
      events[`STS_SFD] = ~rx_summary.sfd_ok; // see [RULE10]
      if (enhanced) begin // see [RULE4]
        events[`STS_CRC] = rx_summary.sfd_ok & ~rx_summary.crc_ok; // see [RULE11]
        events[`STS_HACK] = frame_good & hack;
        events[`STS_UCAST] = frame_good & rx_summary.unicast; // see [RULE13]
        events[`STS_BCAST] = frame_good & rx_summary.broadcast; // see [RULE14]
        events[`STS_PATTERN] = frame_good & rx_summary.pattern_hit; // see [RULE15]
        events[`STS_MAGIC] = frame_good & magic_ok; // see [RULE16]
      end
    end
  end

  // the wake sources share bit positions between config and status
  assign wake_hit = |(events & cfg_q[7:0] &
                      8'h17); // see [RULE6] [RULE7] [RULE8] [RULE9] [RULE19]

  // ************************************
  // status flags and interrupt
  // ************************************
  always_comb begin
    sts_d = sts_q;
    // only what the read returned is cleared; a flag set after setup waits for the next read
    if (rd_done && hit_sts) begin
      sts_d = sts_q & ~prdata_q[7:0];
    end
    // a new event in the clearing cycle survives the read
    sts_d = sts_d | events; // see [RULE19]
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sts_q <= `STS_RESET;
    end else begin
      sts_q <= sts_d; // see [RULE10] [RULE11] [RULE12] [RULE13] [RULE14] [RULE15] [RULE16]
    end
  end

  // irq follows the next mask too, so a mask write never leaves it a cycle behind
  logic [7:0] mask_d;
  assign mask_d = (wr_done && hit_mask) ? (pwdata[7:0] & `STS_USED_MASK) : mask_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(sts_d & mask_d);
    end
  end

  // ************************************
  // timestamp indication
  // ************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_timestamp_event <= 1'b0;
    end else begin
      rx_timestamp_event <= rx_frame_start & enhanced; // see [RULE4]
    end
  end

  // ************************************
  // wake output
  // ************************************
  localparam logic [6:0] PULSE_LEN_0 = 7'(`WAKE_PCLK(`WAKE_REF_CYCLES_0));
  localparam logic [6:0] PULSE_LEN_1 = 7'(`WAKE_PCLK(`WAKE_REF_CYCLES_1));
  localparam logic [6:0] PULSE_LEN_2 = 7'(`WAKE_PCLK(`WAKE_REF_CYCLES_2));
  localparam logic [6:0] PULSE_LEN_3 = 7'(`WAKE_PCLK(`WAKE_REF_CYCLES_3));

  wake_state_t wake_q;
  logic [6:0] pulse_cnt_q;
  logic [6:0] pulse_len;

  always_comb begin
    unique case (stretch)
      2'h0: pulse_len = PULSE_LEN_0; // see [RULE2]
      2'h1: pulse_len = PULSE_LEN_1;
      2'h2: pulse_len = PULSE_LEN_2;
      2'h3: pulse_len = PULSE_LEN_3;
    endcase
  end

  // a new event during a pulse restarts it; the clear bit is ignored while pulsing
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake_q <= WAKE_IDLE;
      pulse_cnt_q <= 7'h00;
    end else begin
      unique case (wake_q)
        WAKE_IDLE: begin
          if (wake_hit && style_level) begin
            wake_q <= WAKE_LEVEL; // see [RULE3]
          end else if (wake_hit) begin
            wake_q <= WAKE_PULSE;
            pulse_cnt_q <= pulse_len - 7'h01; // see [RULE2]
          end
        end
        WAKE_PULSE: begin
          if (wake_hit) begin
            pulse_cnt_q <= pulse_len - 7'h01;
          end else if (pulse_cnt_q == 7'h00) begin
            wake_q <= WAKE_IDLE;
          end else begin
            pulse_cnt_q <= pulse_cnt_q - 7'h01;
          end
        end
        WAKE_LEVEL: begin
          if (cfg_q[`CFG_OUT_CLEAR]) begin
            wake_q <= WAKE_IDLE; // see [RULE1]
          end
        end
        default: begin
          wake_q <= WAKE_IDLE;
        end
      endcase
    end
  end

  assign wake_on_network = wake_q != WAKE_IDLE;

  // ************************************
  // checks
  // ************************************
  // an enabled source reported by a good frame while enhanced receive is on
  logic wake_allowed;
  assign wake_allowed = rx_summary.done & enhanced & frame_good &
                        (rx_summary.unicast & cfg_q[`CFG_UCAST] |
                         rx_summary.broadcast & cfg_q[`CFG_BCAST] |
                         rx_summary.pattern_hit & cfg_q[`CFG_PATTERN] |
                         magic_ok & cfg_q[`CFG_MAGIC]);

  sequence s_pulse_start;
    (wake_q == WAKE_IDLE) && wake_hit && !style_level && stretch == 2'h0;
  endsequence

  sequence s_level_start;
    (wake_q == WAKE_IDLE) && wake_hit && style_level;
  endsequence

  AST_PULSE_SHORT: assert property (@(posedge pclk) disable iff (!presetn) // see [RULE2]
    s_pulse_start ##1 (!wake_hit && !style_level)[*7] |-> ##1 !wake_on_network)
    else $error("short wake pulse has wrong width");

  AST_PULSE_HIGH: assert property (@(posedge pclk) disable iff (!presetn) // see [RULE3]
    s_pulse_start |=> wake_on_network [*7])
    else $error("wake pulse ended early");

  AST_LEVEL_HOLD: assert property (@(posedge pclk) disable iff (!presetn) // see [RULE3]
    s_level_start ##1 !cfg_q[`CFG_OUT_CLEAR] [*8] |-> wake_on_network)
    else $error("level wake dropped without clear");

  AST_LEVEL_CLEAR: assert property (@(posedge pclk) disable iff (!presetn) // see [RULE1]
    (wake_q == WAKE_LEVEL) && cfg_q[`CFG_OUT_CLEAR] |=> !wake_on_network)
    else $error("clear did not drop level wake");

  AST_CLEAR_SELF: assert property (@(posedge pclk) disable iff (!presetn) // see [RULE1]
    cfg_q[`CFG_OUT_CLEAR] && !(wr_done && hit_cfg) |=> !cfg_q[`CFG_OUT_CLEAR])
    else $error("clear bit did not self-clear");

  AST_DISABLED_QUIET: assert property (@(posedge pclk) disable iff (!presetn) // see [RULE4]
    $rose(wake_on_network) |-> $past(enhanced))
    else $error("wake raised while enhanced receive is off");

  AST_WAKE_ENABLED: assert property (@(posedge pclk) disable iff (!presetn) // see [RULE19]
    $rose(wake_on_network) |-> $past(wake_allowed))
    else $error("wake raised without an enabled source");

  AST_FLAG_STICKY: assert property (@(posedge pclk) disable iff (!presetn) // see [RULE13]
    sts_q[`STS_UCAST] && !(rd_done && hit_sts) |=> sts_q[`STS_UCAST])
    else $error("unicast flag lost without a read");

  AST_READ_CLEARS: assert property (@(posedge pclk) disable iff (!presetn) // see [RULE11]
    rd_done && hit_sts && prdata_q[`STS_CRC] && !events[`STS_CRC] |=> !sts_q[`STS_CRC])
    else $error("bad crc flag survived status read");

  AST_SET_WINS: assert property (@(posedge pclk) disable iff (!presetn) // see [RULE10]
    events[`STS_SFD] |=> sts_q[`STS_SFD])
    else $error("delimiter error event lost");

  AST_HACK: assert property (@(posedge pclk) disable iff (!presetn) // see [RULE12]
    rx_summary.done && enhanced && frame_good && rx_summary.magic && cfg_q[`CFG_PW_EN]
    && !pw_match |=> sts_q[`STS_HACK] && (!sts_q[`STS_MAGIC] || $past(sts_q[`STS_MAGIC])))
    else $error("wrong password not flagged");

  AST_RESERVED: assert property (@(posedge pclk) disable iff (!presetn) // see [RULE18]
    (cfg_q & ~(`CFG_WRITE_MASK | 16'h0800)) == 16'h0000 && (sts_q & 8'h08) == 8'h00)
    else $error("reserved bit set");

  AST_CLEAR_PULSE: assert property (@(posedge pclk) disable iff (!presetn) // see [RULE1]
    (wake_q == WAKE_PULSE) && cfg_q[`CFG_OUT_CLEAR] && pulse_cnt_q != 7'h00 |=> wake_on_network)
    else $error("clear bit cut a wake pulse");

  AST_IRQ_LEVEL: assert property (@(posedge pclk) disable iff (!presetn) // see [RULE19]
    irq == |(sts_q & mask_q))
    else $error("irq does not follow unmasked flags");

  AST_TS_GATED: assert property (@(posedge pclk) disable iff (!presetn) // see [RULE4]
    rx_timestamp_event |-> $past(rx_frame_start) && $past(enhanced))
    else $error("timestamp indication without enhanced receive");

endmodule

`default_nettype wire

// file: hw/wake_filter_defs.svh
// register map, field positions, reset values and timing counts of the wake filter
// assumes a 100 MHz pclk and 32-bit apb with word-aligned registers
`ifndef WAKE_FILTER_DEFS_SVH
`define WAKE_FILTER_DEFS_SVH

// ************************************
// register indices, byte address is four times the index
// ************************************
`define CFG_INDEX 12'h134
`define STS_INDEX 12'h135
`define PW0_INDEX 12'h139
`define PW1_INDEX 12'h13a
`define PW2_INDEX 12'h13b
`define MASK_INDEX 12'h150
`define BYTE_ADDR(idx) (12'({(idx), 2'h0}))

// ************************************
// config fields
// ************************************
`define CFG_OUT_CLEAR 11
`define CFG_STRETCH_HI 10
`define CFG_STRETCH_LO 9
`define CFG_OUT_STYLE 8
`define CFG_ENHANCED 7
`define CFG_PW_EN 5
`define CFG_UCAST 4
`define CFG_BCAST 2
`define CFG_PATTERN 1
`define CFG_MAGIC 0
`define CFG_WRITE_MASK 16'h0fb7
`define CFG_RESET 16'h0004

// ************************************
// status fields
// ************************************
`define STS_SFD 7
`define STS_CRC 6
`define STS_HACK 5
`define STS_UCAST 4
`define STS_BCAST 2
`define STS_PATTERN 1
`define STS_MAGIC 0
`define STS_USED_MASK 8'hf7
`define STS_RESET 8'h00

// ************************************
// pulse timing: reference-clock periods converted to pclk cycles, rounded up
// ************************************
`define WAKE_REF_PERIOD_PS 8000
`define PCLK_PERIOD_PS 10000
`define WAKE_REF_CYCLES_0 8
`define WAKE_REF_CYCLES_1 16
`define WAKE_REF_CYCLES_2 32
`define WAKE_REF_CYCLES_3 64
`define WAKE_PCLK(n) (((n) * `WAKE_REF_PERIOD_PS + `PCLK_PERIOD_PS - 1) / `PCLK_PERIOD_PS)

`endif

// file: hw/wake_filter_pkg.sv
// types shared by the wake filter and its surroundings
// assumes the receive path reports one summary per finished frame
package wake_filter_pkg;

  // one frame's verdict from the receive path, valid for one cycle
  typedef struct packed {
    logic done;
    logic sfd_ok;
    logic crc_ok;
    logic unicast;
    logic broadcast;
    logic pattern_hit;
    logic magic;
    logic password_seen;
    logic [47:0] password;
  } rx_summary_t;

  typedef enum logic [2:0] {
    WAKE_IDLE = 3'b001,
    WAKE_PULSE = 3'b010,
    WAKE_LEVEL = 3'b100
  } wake_state_t;

endpackage

// file: tb/frame_source.sv
// stand-in for the receive path: one verdict per frame
// assumes pclk from the bench; frames are sent with the send task
`timescale 1ns/100ps
`default_nettype none
module frame_source (
  // clock
  input wire logic pclk,
  // receive path
  output wake_filter_pkg::rx_summary_t rx_summary,
  output logic rx_frame_start
);
  import wake_filter_pkg::*;
  initial begin
    rx_summary = '0;
    rx_frame_start = 1'b0;
  end
  // ****
  // one frame
  // ****
  // kind: sfd, crc, unicast, broadcast, pattern, magic, password seen
  // gap makes a slow frame; idle fields show the inverse, not stale data
  task automatic send(input logic [6:0] kind, input logic [47:0] pw, input int gap);
    rx_summary_t s;
    s = '0;
    s.done = 1'b1;
    {s.sfd_ok, s.crc_ok, s.unicast, s.broadcast, s.pattern_hit, s.magic, s.password_seen} = kind;
    s.password = pw;
    @(posedge pclk);
    rx_frame_start <= 1'b1;
    @(posedge pclk);
    rx_frame_start <= 1'b0;
    repeat (gap) @(posedge pclk);
    rx_summary <= s;
    @(posedge pclk);
    s = ~s;
    s.done = 1'b0;
    rx_summary <= s;
  endtask
endmodule
`default_nettype wire

// file: tb/testbench.sv
// self-checking bench for the wake filter: apb master and frame source
// assumes the design header and package are compiled first
`timescale 1ns/100ps
`default_nettype none
`include "wake_filter_defs.svh"
module testbench;
  import wake_filter_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, ts, wake, irq, err;
  logic [31:0] rd;
  rx_summary_t rx_summary;
  logic rx_frame_start;
  int n_errors = 0;
  int n_compared = 0;
  int n_ts = 0;
  always #5 pclk = ~pclk;
  // counted mid-cycle, away from the flop updates
  always @(negedge pclk) if (ts === 1'b1) n_ts++;
  wake_on_network_filter uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rx_summary(rx_summary), .rx_frame_start(rx_frame_start),
    .rx_timestamp_event(ts), .wake_on_network(wake), .irq(irq));
  frame_source src (.pclk(pclk), .rx_summary(rx_summary), .rx_frame_start(rx_frame_start));
  // ****
  // shared tasks
  // ****
  task automatic end_sim();
    $display("errors %0d compared %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  // leading edge keeps a release and the next setup apart
  task automatic apb(input logic wr, input logic [11:0] idx, input logic [31:0] wd);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {idx[9:0], 2'h0};
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (i == 20) begin
      n_errors++;
      end_sim();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic count_wake(output int n);
    n = 0;
    while (wake === 1'b1 && n < 200) begin
      @(posedge pclk);
      #1;
      n++;
    end
    if (n == 200) begin
      n_errors++;
      end_sim();
    end
  endtask
  // ****
  // scenarios
  // ****
  task automatic reg_defaults();
    apb(1'b0, `CFG_INDEX, 32'h0);
    chk(rd, 32'h4, "cfg reset");
    apb(1'b0, `STS_INDEX, 32'h0);
    chk(rd, 32'h0, "status reset");
    apb(1'b1, `CFG_INDEX, 32'hffffffff);
    apb(1'b0, `CFG_INDEX, 32'h0);
    chk(rd, 32'h7b7, "reserved bits");
    apb(1'b0, 12'h1ff, 32'h0);
    chk({31'h0, err}, 32'h1, "unmapped error");
    chk(rd, 32'h0, "unmapped data");
    apb(1'b1, `PW0_INDEX, 32'h89ab);
    apb(1'b1, `PW1_INDEX, 32'h4567);
    apb(1'b1, `PW2_INDEX, 32'h0123);
    apb(1'b0, `PW2_INDEX, 32'h0);
    chk(rd, 32'h123, "password high");
    $display("register defaults done");
  endtask
  task automatic pulse_widths();
    int n;
    int len;
    apb(1'b1, `MASK_INDEX, 32'h31);
    for (len = 0; len < 4; len++) begin
      apb(1'b1, `CFG_INDEX, 32'h90 | (len << 9));
      src.send(7'b1110000, 48'h0, len * 3);
      #1;
      count_wake(n);
      chk(n, ((8 << len) * 8 + 9) / 10, "pulse width");
      apb(1'b0, `STS_INDEX, 32'h0);
      chk(rd, 32'h10, "unicast flag");
    end
    $display("pulse widths done");
  endtask
  task automatic level_mode();
    int n;
    apb(1'b1, `CFG_INDEX, 32'h184);
    src.send(7'b1101000, 48'h0, 1);
    repeat (70) @(posedge pclk);
    #1;
    chk(wake, 1'b1, "level held");
    apb(1'b1, `CFG_INDEX, 32'h984);
    repeat (2) @(posedge pclk);
    #1;
    chk(wake, 1'b0, "level cleared");
    apb(1'b0, `CFG_INDEX, 32'h0);
    chk(rd, 32'h184, "clear bit gone");
    apb(1'b0, `STS_INDEX, 32'h0);
    // longest pulse, then the clear bit written while it runs
    apb(1'b1, `CFG_INDEX, 32'h684);
    src.send(7'b1101000, 48'h0, 0);
    apb(1'b1, `CFG_INDEX, 32'he84);
    repeat (2) @(posedge pclk);
    #1;
    chk(wake, 1'b1, "clear ignored in pulse mode");
    count_wake(n);
    chk(n, (64 * 8 + 9) / 10 - 5, "pulse kept its length");
    apb(1'b0, `STS_INDEX, 32'h0);
    $display("level mode done");
  endtask
  // mask 0x31 lets magic, hack and unicast reach irq
  task automatic one_event(input logic [15:0] cfg, input logic [6:0] kind,
      input logic [47:0] pw, input logic [7:0] sts, input logic w);
    apb(1'b1, `CFG_INDEX, {16'h0, cfg});
    src.send(kind, pw, 2);
    #1;
    chk(wake, w, "wake");
    chk(irq, |(sts & 8'h31), "irq");
    apb(1'b0, `STS_INDEX, 32'h0);
    chk(rd, {24'h0, sts}, "status");
    apb(1'b0, `STS_INDEX, 32'h0);
    chk(rd, 32'h0, "status cleared");
    chk(irq, 1'b0, "irq cleared");
    repeat (10) @(posedge pclk);
  endtask
  task automatic event_table();
    int t0;
    t0 = n_ts;
    one_event(16'h90, 7'b1110000, 48'h0, 8'h10, 1'b1);
    one_event(16'h80, 7'b1110000, 48'h0, 8'h10, 1'b0);
    one_event(16'h84, 7'b1101000, 48'h0, 8'h04, 1'b1);
    one_event(16'h82, 7'b1100100, 48'h0, 8'h02, 1'b1);
    one_event(16'h81, 7'b1100010, 48'h0, 8'h01, 1'b1);
    one_event(16'ha1, 7'b1100011, 48'h89ab45670123, 8'h20, 1'b0);
    one_event(16'ha1, 7'b1100011, 48'h0123456789ab, 8'h01, 1'b1);
    one_event(16'h90, 7'b1010000, 48'h0, 8'h40, 1'b0);
    one_event(16'h10, 7'b1110000, 48'h0, 8'h00, 1'b0);
    one_event(16'h10, 7'b0110000, 48'h0, 8'h80, 1'b0);
    chk(n_ts - t0, 8, "timestamp count");
    $display("event table done");
  endtask
  // reset in mid-run, with a level wake and a flag standing
  task automatic mid_reset();
    apb(1'b1, `CFG_INDEX, 32'h184);
    src.send(7'b1101000, 48'h0, 0);
    #1;
    chk(wake, 1'b1, "wake before reset");
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    #1;
    chk(wake, 1'b0, "wake after reset");
    chk(irq, 1'b0, "irq after reset");
    apb(1'b0, `CFG_INDEX, 32'h0);
    chk(rd, {16'h0000, `CFG_RESET}, "cfg after reset");
    apb(1'b0, `STS_INDEX, 32'h0);
    chk(rd, 32'h0, "status after reset");
    $display("mid-run reset done");
  endtask
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    reg_defaults();
    pulse_widths();
    level_mode();
    event_table();
    mid_reset();
    end_sim();
  end
endmodule
`default_nettype wire
